// ===== inc/ascs_pkg.sv
// Purpose: constants and types of the serial port control and status block
// Assumes: one 125 MHz bus clock, APB with 32-bit data
// Notes: every register is one aligned word, data in bits 7:0, baud divider in bits 15:0
package ascs_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] OFS_CTRL_ONE = 12'h000;
    localparam logic [11:0] OFS_CTRL_TWO = 12'h004;
    localparam logic [11:0] OFS_CTRL_THREE = 12'h008;
    localparam logic [11:0] OFS_STAT_ONE = 12'h00C;
    localparam logic [11:0] OFS_DATA_BUF = 12'h010;
    localparam logic [11:0] OFS_BAUD_DIV = 12'h014;

    // ************************************************************
    // Field positions
    // ************************************************************
    // ctrl_one
    localparam int C1_MODULE_ON = 6;
    localparam int C1_MODE9 = 4;
    localparam int C1_ROUSE_SEL = 3;
    localparam int C1_PARITY_ON = 1;
    localparam int C1_ODD_PARITY = 0;
    // ctrl_two
    localparam int C2_TXE_IE = 7;
    localparam int C2_TXDONE_IE = 6;
    localparam int C2_RXFULL_IE = 5;
    localparam int C2_IDLE_IE = 4;
    localparam int C2_TX_ON = 3;
    localparam int C2_RX_ON = 2;
    localparam int C2_RX_SLEEP = 1;
    localparam int C2_BREAK = 0;
    // ctrl_three, bits 3:0 are the error enables in stat_one order
    localparam int C3_RX_NINTH = 7;
    localparam int C3_TX_NINTH = 6;
    // stat_one
    localparam int S1_TXE = 7;
    localparam int S1_TXDONE = 6;
    localparam int S1_RXFULL = 5;
    localparam int S1_QUIET = 4;
    localparam int S1_OVERRUN = 3;
    localparam int S1_NOISE = 2;
    localparam int S1_FRAMING = 1;
    localparam int S1_PARITY = 0;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] CTRL_THREE_RST = 8'h00;
    localparam logic [7:0] STAT_ONE_RST = 8'hC0;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0010;
    localparam logic [3:0] LEN_CHAR8 = 4'hA;
    localparam logic [3:0] LEN_CHAR9 = 4'hB;
    localparam logic [7:0] RX_FLAG_MASK = 8'h3F;

    typedef enum logic {TX_IDLE, TX_SHIFT} ascs_tx_type;
    typedef enum logic {RX_IDLE, RX_SHIFT} ascs_rx_type;

    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic [7:0] stat;
        logic [7:0] arm;
        logic [15:0] baudDiv;
        logic [7:0] txBuf;
        ascs_tx_type txState;
        logic [10:0] txShift;
        logic [3:0] txLeft;
        logic [15:0] txDiv;
        logic txOnPrev;
        logic onesPend;
        logic breakTail;
        logic serOut;
        ascs_rx_type rxState;
        logic [9:0] rxShift;
        logic [3:0] rxLeft;
        logic [15:0] rxDiv;
        logic rxNoise;
        logic [7:0] rxData;
        logic [2:0] sync;
        logic rxLine;
        logic [3:0] idleCnt;
        logic idleArm;
        logic [31:0] prdata;
        logic err;
        logic txIrq;
        logic rxIrq;
        logic errIrq;
    } ascs_state_type;

endpackage : ascs_pkg

// ===== hw/ascs_ctrl_status.sv
// Purpose: control and status logic of an asynchronous serial port
// Assumes: APB slave without wait states, serIn from another domain
// Notes: one bit time is baudDiv bus clocks
// Notes on behaviour
// - Parity on puts parity bit in the top data position, checked on receive.
// - Odd parity select: one means odd parity, zero means even parity.
// - Transmit request: buffer empty with its enable, or done with its enable.
// - Receive request when receive buffer full and its enable are set.
// - Receive request also when line quiet flag and idle enable are set.
// - Transmitter enable rising sends one all-ones character of current length, dropped if break is set.
// - Transmitter disable finishes the character, then line stays high.
// - Disable then enable during a character queues one idle character.
// - Receiver enable starts reception; disabling keeps receive flags unchanged.
// - Sleep suppresses receive interrupts; selected wake condition clears sleep.
// - Break sends zero characters back to back, then one stop bit.
// - Received ninth bit stored with data; eight-bit mode copies bit seven.
// - Transmit ninth bit loads into shifter together with the data buffer.
// - Error request when any error flag and its own enable are set.
// - Buffer empty sets on transfer; clears by status read then data write.
// - Done flag when buffer empty and nothing queued or shifting.
// - Receive full sets on transfer; clears by status read then data read.
// - Line quiet after one idle character, armed only by a received character.
// - Overrun keeps the buffered character; cleared by armed status then data read.
// - Module off forces empty, and done unless transmit enable and break are both set; disables transmit interrupts.
// - Wake select one: top data bit set wakes; zero: idle line wakes.
`timescale 1ns/100ps
`default_nettype none

module ascs_ctrl_status
    import ascs_pkg::*;
(
    input wire logic sysClk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serIn,
    output logic serOut,
    output logic txIrq,
    output logic rxIrq,
    output logic errIrq
);

    ascs_state_type s_q;
    ascs_state_type s_d;

    logic setup;
    logic access;
    logic modOn;
    logic mode9;
    logic txGo;
    logic txTick;
    logic txSlot;
    logic rxTick;
    logic rxDone;
    logic lineNew;
    logic [3:0] charLen;
    logic [10:0] dataFrame;
    logic [9:0] newShift;
    logic rxMsb;
    logic rxAccept;
    logic parOk;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign pslverr = access && s_q.err;
    assign prdata = s_q.prdata;
    assign serOut = s_q.serOut;
    assign txIrq = s_q.txIrq;
    assign rxIrq = s_q.rxIrq;
    assign errIrq = s_q.errIrq;

    assign modOn = s_q.c1[C1_MODULE_ON];
    assign mode9 = s_q.c1[C1_MODE9];
    assign charLen = mode9 ? LEN_CHAR9 : LEN_CHAR8;
    assign txGo = modOn && s_q.c2[C2_TX_ON];
    assign txTick = modOn && (s_q.txDiv == 16'h0000);
    assign txSlot = txTick
        && (s_q.txState == TX_IDLE || s_q.txLeft == 4'h1);
    assign lineNew = (s_q.sync[1] == s_q.sync[2]) ? s_q.sync[2] : s_q.rxLine;
    assign rxTick = (s_q.rxState == RX_SHIFT) && (s_q.rxDiv == 16'h0000);
    assign rxDone = rxTick && (s_q.rxLeft == 4'h1);
    assign newShift = {s_q.rxLine, s_q.rxShift[9:1]};
    assign rxMsb = newShift[8];
    assign rxAccept = !s_q.c2[C2_RX_SLEEP]
        || (s_q.c1[C1_ROUSE_SEL] && rxMsb);

    // ************************************************************
    // Character framing
    // ************************************************************
    always_comb begin
        logic b7;
        logic b8;
        b7 = s_q.txBuf[7];
        b8 = s_q.c3[C3_TX_NINTH];
        if (s_q.c1[C1_PARITY_ON]) begin
            if (mode9) begin
                b8 = ^s_q.txBuf ^ s_q.c1[C1_ODD_PARITY];
            end else begin
                b7 = ^s_q.txBuf[6:0] ^ s_q.c1[C1_ODD_PARITY];
            end
        end
        if (mode9) begin
            dataFrame = {1'b1, b8, b7, s_q.txBuf[6:0], 1'b0};
        end else begin
            dataFrame = {2'b11, b7, s_q.txBuf[6:0], 1'b0};
        end
        if (mode9) begin
            parOk = (^newShift[8:0]) == s_q.c1[C1_ODD_PARITY];
        end else begin
            parOk = (^newShift[8:1]) == s_q.c1[C1_ODD_PARITY];
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], serIn};
        s_d.rxLine = lineNew;

        // Bit clock for the transmitter and idle counting
        if (!modOn || txTick) begin
            s_d.txDiv = s_q.baudDiv - 16'h0001;
        end else begin
            s_d.txDiv = s_q.txDiv - 16'h0001;
        end

        // Transmitter
        if (s_q.txState == TX_SHIFT && txTick && s_q.txLeft != 4'h1) begin
            s_d.txShift = {1'b1, s_q.txShift[10:1]};
            s_d.txLeft = s_q.txLeft - 4'h1;
            s_d.serOut = s_q.txShift[1];
        end
        if (txSlot) begin
            s_d.txState = TX_SHIFT;
            s_d.txLeft = charLen;
            if (txGo && s_q.c2[C2_BREAK]) begin
                s_d.txShift = 11'h000;
                s_d.breakTail = 1'b1;
                s_d.onesPend = 1'b0;
            end else if (txGo && s_q.onesPend) begin
                s_d.txShift = 11'h7FF;
                s_d.onesPend = 1'b0;
            end else if (s_q.breakTail) begin
                s_d.txShift = 11'h7FF;
                s_d.txLeft = 4'h1;
                s_d.breakTail = 1'b0;
            end else if (txGo && !s_q.stat[S1_TXE]) begin
                s_d.txShift = dataFrame;
                s_d.stat[S1_TXE] = 1'b1;
            end else begin
                s_d.txState = TX_IDLE;
                s_d.txShift = 11'h7FF;
            end
            s_d.serOut = s_d.txShift[0];
        end
        s_d.txOnPrev = s_q.c2[C2_TX_ON];
        if (modOn && s_q.c2[C2_TX_ON] && !s_q.txOnPrev) begin
            s_d.onesPend = 1'b1;
        end

        // Receiver
        if (!(modOn && s_q.c2[C2_RX_ON])) begin
            s_d.rxState = RX_IDLE;
            s_d.idleCnt = 4'h0;
            s_d.idleArm = 1'b0;
        end else if (s_q.rxState == RX_IDLE) begin
            if (s_q.rxLine && !lineNew) begin
                s_d.rxState = RX_SHIFT;
                // Sample early so both late synchroniser flops hold one bit
                s_d.rxDiv = {1'b0, s_q.baudDiv[15:1]} - 16'h0001;
                s_d.rxLeft = charLen;
                s_d.rxNoise = 1'b0;
                s_d.idleCnt = 4'h0;
            end else if (!s_q.rxLine) begin
                s_d.idleCnt = 4'h0;
            end else if (txTick && s_q.idleCnt != charLen) begin
                s_d.idleCnt = s_q.idleCnt + 4'h1;
                if (s_q.idleCnt + 4'h1 == charLen) begin
                    if (s_q.c2[C2_RX_SLEEP] && !s_q.c1[C1_ROUSE_SEL]) begin
                        s_d.c2[C2_RX_SLEEP] = 1'b0;
                    end else if (s_q.idleArm && !s_q.c2[C2_RX_SLEEP]) begin
                        s_d.stat[S1_QUIET] = 1'b1;
                        s_d.idleArm = 1'b0;
                    end
                end
            end
        end else if (rxTick) begin
            s_d.rxDiv = s_q.baudDiv - 16'h0001;
            s_d.rxLeft = s_q.rxLeft - 4'h1;
            s_d.rxShift = newShift;
            if (s_q.sync[1] != s_q.sync[2]) begin
                s_d.rxNoise = 1'b1;
            end
            if (s_q.rxLeft == charLen && s_q.rxLine) begin
                s_d.rxState = RX_IDLE;
            end else if (rxDone) begin
                s_d.rxState = RX_IDLE;
                if (s_q.c2[C2_RX_SLEEP] && rxAccept) begin
                    s_d.c2[C2_RX_SLEEP] = 1'b0;
                end
                if (rxAccept && s_q.stat[S1_RXFULL]) begin
                    s_d.stat[S1_OVERRUN] = 1'b1;
                end else if (rxAccept) begin
                    s_d.rxData = mode9 ? newShift[7:0] : newShift[8:1];
                    s_d.c3[C3_RX_NINTH] = newShift[8];
                    s_d.stat[S1_RXFULL] = 1'b1;
                    s_d.idleArm = 1'b1;
                    s_d.stat[S1_FRAMING] = !s_q.rxLine;
                    s_d.stat[S1_NOISE] = s_d.rxNoise;
                    s_d.stat[S1_PARITY] = s_q.c1[C1_PARITY_ON] && !parOk;
                end
            end
        end else begin
            s_d.rxDiv = s_q.rxDiv - 16'h0001;
        end

        // Register access; flag sets above win over clears
        s_d.err = s_q.err;
        if (setup) begin
            s_d.err = 1'b0;
            s_d.prdata = 32'h0000_0000;
            if (paddr == OFS_CTRL_ONE) begin
                s_d.prdata[7:0] = s_q.c1;
            end else if (paddr == OFS_CTRL_TWO) begin
                s_d.prdata[7:0] = s_q.c2;
            end else if (paddr == OFS_CTRL_THREE) begin
                s_d.prdata[7:0] = s_q.c3;
            end else if (paddr == OFS_STAT_ONE) begin
                s_d.prdata[7:0] = s_q.stat;
            end else if (paddr == OFS_DATA_BUF) begin
                s_d.prdata[7:0] = s_q.rxData;
            end else if (paddr == OFS_BAUD_DIV) begin
                s_d.prdata[15:0] = s_q.baudDiv;
            end else begin
                s_d.err = 1'b1;
            end
        end
        if (access && !s_q.err) begin
            if (pwrite) begin
                if (paddr == OFS_CTRL_ONE) begin
                    s_d.c1 = pwdata[7:0];
                end else if (paddr == OFS_CTRL_TWO) begin
                    s_d.c2 = pwdata[7:0];
                end else if (paddr == OFS_CTRL_THREE) begin
                    s_d.c3 = {s_q.c3[C3_RX_NINTH], pwdata[6:0]};
                end else if (paddr == OFS_DATA_BUF) begin
                    s_d.txBuf = pwdata[7:0];
                    if (s_q.arm[S1_TXE]) begin
                        s_d.stat[S1_TXE] = 1'b0;
                    end
                    s_d.arm[S1_TXE] = 1'b0;
                end else if (paddr == OFS_BAUD_DIV) begin
                    s_d.baudDiv = pwdata[15:0];
                end
            end else if (paddr == OFS_STAT_ONE) begin
                s_d.arm = s_q.stat;
            end else if (paddr == OFS_DATA_BUF) begin
                s_d.stat = s_d.stat & ~(s_q.arm & RX_FLAG_MASK
                    & ~(s_d.stat ^ s_q.stat));
                s_d.arm = s_q.arm & ~RX_FLAG_MASK;
            end
        end

        // Module off forces the transmit side quiet
        if (!s_d.c1[C1_MODULE_ON]) begin
            s_d.stat[S1_TXE] = 1'b1;
            s_d.txState = TX_IDLE;
            s_d.serOut = 1'b1;
            s_d.onesPend = 1'b0;
            s_d.breakTail = 1'b0;
        end
        s_d.stat[S1_TXDONE] = s_d.stat[S1_TXE] && s_d.txState == TX_IDLE
            && !s_d.onesPend && !s_d.breakTail
            && !(s_d.c2[C2_TX_ON] && s_d.c2[C2_BREAK]);

        // Interrupt levels
        s_d.txIrq = modOn
            && ((s_q.stat[S1_TXE] && s_q.c2[C2_TXE_IE])
            || (s_q.stat[S1_TXDONE] && s_q.c2[C2_TXDONE_IE]));
        s_d.rxIrq = !s_q.c2[C2_RX_SLEEP]
            && ((s_q.stat[S1_RXFULL] && s_q.c2[C2_RXFULL_IE])
            || (s_q.stat[S1_QUIET] && s_q.c2[C2_IDLE_IE]));
        s_d.errIrq = |(s_q.stat[3:0] & s_q.c3[3:0]);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sysClk) begin
        if (rst) begin
            s_q <= '0;
            s_q.c1 <= CTRL_ONE_RST;
            s_q.c2 <= CTRL_TWO_RST;
            s_q.c3 <= CTRL_THREE_RST;
            s_q.stat <= STAT_ONE_RST;
            s_q.baudDiv <= BAUD_DIV_RST;
            s_q.txShift <= 11'h7FF;
            s_q.serOut <= 1'b1;
            s_q.sync <= 3'h7;
            s_q.rxLine <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sysClk);
    endclocking
    default disable iff (rst);

    sequence ones_start;
        txSlot && txGo && s_q.onesPend && !s_q.c2[C2_BREAK];
    endsequence

    sequence break_start;
        txSlot && txGo && s_q.c2[C2_BREAK];
    endsequence

    preamble_ones_a: assert property (ones_start |=> s_q.serOut
        && s_q.txLeft == charLen) else $error("preamble not all ones");
    break_zero_a: assert property (break_start |=> !s_q.serOut
        && s_q.breakTail) else $error("break not low");
    tx_stop_a: assert property (txSlot && !txGo && !s_q.breakTail
        |=> s_q.serOut && s_q.txState == TX_IDLE)
        else $error("line not idle after disable");
    off_force_a: assert property (!modOn |=> s_q.stat[S1_TXE]
        && s_q.stat[S1_TXDONE]) else $error("module off not forcing");
    tx_irq_a: assert property (modOn && s_q.stat[S1_TXE]
        && s_q.c2[C2_TXE_IE] |=> txIrq) else $error("tx request lost");
    rx_irq_a: assert property (s_q.stat[S1_RXFULL] && s_q.c2[C2_RXFULL_IE]
        && !s_q.c2[C2_RX_SLEEP] |=> rxIrq)
        else $error("rx request lost");
    quiet_irq_a: assert property (s_q.stat[S1_QUIET] && s_q.c2[C2_IDLE_IE]
        && !s_q.c2[C2_RX_SLEEP] |=> rxIrq)
        else $error("idle request lost");
    sleep_quiet_a: assert property (s_q.c2[C2_RX_SLEEP] |=> !rxIrq)
        else $error("request while asleep");
    err_irq_a: assert property (s_q.stat[S1_OVERRUN] && s_q.c3[3]
        |=> errIrq) else $error("error request lost");
    overrun_keep_a: assert property (rxDone && rxAccept
        && s_q.stat[S1_RXFULL] |=> $stable(s_q.rxData)
        && s_q.stat[S1_OVERRUN]) else $error("overrun lost buffer");
    ninth_store_a: assert property (rxDone && rxAccept
        && !s_q.stat[S1_RXFULL] |=> s_q.c3[C3_RX_NINTH] == $past(rxMsb)
        && s_q.stat[S1_RXFULL]) else $error("ninth bit wrong");
    wake_mark_a: assert property (rxDone && s_q.c2[C2_RX_SLEEP]
        && s_q.c1[C1_ROUSE_SEL] && rxMsb
        |=> !s_q.c2[C2_RX_SLEEP] || $past(access && pwrite))
        else $error("address mark did not wake");
    done_flag_a: assert property (s_q.stat[S1_TXDONE]
        |-> s_q.stat[S1_TXE] && s_q.txState == TX_IDLE)
        else $error("done while busy");

endmodule : ascs_ctrl_status

`default_nettype wire

// ===== sim/ascs_serial_node.sv
// Purpose: remote serial node that sends and captures characters
// Assumes: fixed bit time of BIT_CLKS bus clocks, idle line high
// Notes: frames are given and returned LSB first, start bit in bit 0
`timescale 1ns/100ps
`default_nettype none

module ascs_serial_node
    import ascs_pkg::*;
#(
    parameter int BIT_CLKS = 4
)
(
    input wire logic sysClk,
    input wire logic lineIn,
    output logic lineOut
);
    // ********
    // Line driver and sampler
    // ********
    initial begin
        lineOut = 1'b1;
    end

    // Frames end on a stop bit, so the line rests high afterwards
    task automatic send_char(input logic [10:0] frame, input int n);
        for (int i = 0; i < n; i++) begin
            lineOut <= frame[i];
            repeat (BIT_CLKS) @(posedge sysClk);
        end
    endtask : send_char

    task automatic get_char(input int n, output logic [10:0] frame,
                            output time t);
        int k;
        k = 0;
        frame = '1;
        while (lineIn !== 1'b0 && k < 400) begin
            @(posedge sysClk);
            k++;
        end
        t = $time;
        repeat (BIT_CLKS / 2) @(posedge sysClk);
        for (int i = 0; i < n; i++) begin
            frame[i] = lineIn;
            repeat (BIT_CLKS) @(posedge sysClk);
        end
    endtask : get_char
endmodule : ascs_serial_node

`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench of the serial control and status block
// Assumes: bit time of four clocks, remote node model on the line
// Notes: APB master waits for pready under a bounded count
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import ascs_pkg::*;
;
    logic sysClk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serIn;
    logic serOut;
    logic txIrq;
    logic rxIrq;
    logic errIrq;
    logic lastErr;
    logic [31:0] rdv;
    int errCount = 0;
    int comparisons = 0;

    always #4 sysClk = ~sysClk;

    ascs_ctrl_status i_dut (.sysClk(sysClk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .serIn(serIn),
        .serOut(serOut), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq));

    ascs_serial_node #(.BIT_CLKS(4)) i_node (.sysClk(sysClk),
        .lineIn(serOut), .lineOut(serIn));

    // ********
    // Bus and compare tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sysClk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "pready timeout");
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sysClk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rdv);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [7:0] e,
                       input string m);
        apb(1'b0, a, 32'h0, rdv);
        chk(rdv, {24'h0, e}, m);
    endtask : rdc

    // ********
    // Scenarios
    // ********
    task automatic test_regs();
        rdc(OFS_CTRL_ONE, CTRL_ONE_RST, "c1 reset");
        rdc(OFS_CTRL_TWO, CTRL_TWO_RST, "c2 reset");
        rdc(OFS_CTRL_THREE, CTRL_THREE_RST, "c3 reset");
        rdc(OFS_STAT_ONE, STAT_ONE_RST, "stat reset");
        wr(OFS_STAT_ONE, 8'h00);
        rdc(OFS_STAT_ONE, 8'hC0, "stat read only");
        wr(OFS_CTRL_THREE, 8'hFF);
        rdc(OFS_CTRL_THREE, 8'h7F, "c3 access");
        apb(1'b0, 12'h0FC, 32'h0, rdv);
        chk(32'(lastErr), 32'h1, "unmapped");
        wr(OFS_BAUD_DIV, 8'h04);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_tx();
        logic [10:0] f;
        logic [10:0] e;
        logic [7:0] d;
        logic m9;
        logic odd;
        time t0;
        time t1;
        int n;
        int dt;
        for (int k = 0; k < 3; k++) begin
            m9 = (k == 2);
            odd = (k == 1);
            d = m9 ? 8'hC6 : 8'h35;
            n = m9 ? 11 : 10;
            wr(OFS_CTRL_ONE, {3'b010, m9, 2'b00, ~m9, odd});
            wr(OFS_CTRL_TWO, 8'h00);
            wr(OFS_CTRL_THREE, {1'b0, m9, 6'h00});
            wr(OFS_CTRL_TWO, 8'h88);
            t0 = $time;
            rdc(OFS_STAT_ONE, 8'h80, "preamble queued");
            wr(OFS_DATA_BUF, d);
            i_node.get_char(n, f, t1);
            e = m9 ? {2'b11, d, 1'b0} : {2'b11, ^d[6:0] ^ odd, d[6:0], 1'b0};
            chk(32'(f), 32'(e), "frame");
            dt = int'((t1 - t0) / 8);
            chk(32'(dt >= n * 4 - 1 && dt <= n * 4 + 5), 32'h1, "lead");
            repeat (4) @(posedge sysClk);
            chk(32'(txIrq), 32'h1, "empty irq");
            wr(OFS_CTRL_TWO, 8'h08);
            @(posedge sysClk);
            chk(32'(txIrq), 32'h0, "irq masked");
            wr(OFS_CTRL_TWO, 8'h48);
            @(posedge sysClk);
            chk(32'(txIrq), 32'h1, "done irq");
        end
        wr(OFS_CTRL_TWO, 8'h09);
        i_node.get_char(11, f, t1);
        chk(32'(f), 32'h0, "break frame");
        wr(OFS_CTRL_TWO, 8'h08);
        repeat (100) @(posedge sysClk);
        chk(32'(serOut), 32'h1, "line idle");
        rdc(OFS_STAT_ONE, 8'hC0, "done after break");
        $display("test_tx done");
    endtask : test_tx

    task automatic test_rx();
        wr(OFS_CTRL_ONE, 8'h40);
        wr(OFS_CTRL_THREE, 8'h08);
        wr(OFS_CTRL_TWO, 8'h34);
        i_node.send_char({2'b11, 8'hA5, 1'b0}, 10);
        repeat (4) @(posedge sysClk);
        chk(32'(rxIrq), 32'h1, "full irq");
        rdc(OFS_STAT_ONE, 8'hE0, "rx full");
        rdc(OFS_DATA_BUF, 8'hA5, "rx data");
        rdc(OFS_CTRL_THREE, 8'h88, "ninth copy");
        repeat (60) @(posedge sysClk);
        chk(32'(rxIrq), 32'h1, "idle irq");
        rdc(OFS_STAT_ONE, 8'hD0, "line quiet");
        rdc(OFS_DATA_BUF, 8'hA5, "data kept");
        repeat (60) @(posedge sysClk);
        rdc(OFS_STAT_ONE, 8'hC0, "quiet disarmed");
        chk(32'(rxIrq), 32'h0, "rx irq off");
        i_node.send_char({2'b11, 8'h11, 1'b0}, 10);
        i_node.send_char({2'b11, 8'h22, 1'b0}, 10);
        repeat (4) @(posedge sysClk);
        chk(32'(errIrq), 32'h1, "error irq");
        rdc(OFS_STAT_ONE, 8'hE8, "overrun");
        rdc(OFS_DATA_BUF, 8'h11, "first kept");
        rdc(OFS_STAT_ONE, 8'hC0, "overrun cleared");
        chk(32'(errIrq), 32'h0, "error irq off");
        i_node.send_char({2'b11, 8'h3C, 1'b0}, 10);
        repeat (4) @(posedge sysClk);
        wr(OFS_CTRL_TWO, 8'h00);
        rdc(OFS_STAT_ONE, 8'hE0, "flags after rx off");
        rdc(OFS_DATA_BUF, 8'h3C, "data after rx off");
        $display("test_rx done");
    endtask : test_rx

    task automatic test_sleep();
        wr(OFS_CTRL_ONE, 8'h48);
        wr(OFS_CTRL_TWO, 8'h26);
        i_node.send_char({2'b11, 8'h12, 1'b0}, 10);
        repeat (4) @(posedge sysClk);
        chk(32'(rxIrq), 32'h0, "standby quiet");
        rdc(OFS_CTRL_TWO, 8'h26, "still asleep");
        i_node.send_char({2'b11, 8'h92, 1'b0}, 10);
        repeat (4) @(posedge sysClk);
        rdc(OFS_CTRL_TWO, 8'h24, "woken");
        apb(1'b0, OFS_STAT_ONE, 32'h0, rdv);
        apb(1'b0, OFS_DATA_BUF, 32'h0, rdv);
        wr(OFS_CTRL_ONE, 8'h40);
        wr(OFS_CTRL_TWO, 8'h26);
        i_node.send_char({2'b11, 8'h12, 1'b0}, 10);
        repeat (4) @(posedge sysClk);
        rdc(OFS_CTRL_TWO, 8'h26, "idle wait");
        repeat (60) @(posedge sysClk);
        rdc(OFS_CTRL_TWO, 8'h24, "idle wake");
        wr(OFS_CTRL_TWO, 8'h00);
        wr(OFS_CTRL_ONE, 8'h40);
        rdc(OFS_STAT_ONE, 8'hC0, "flags clear");
        wr(OFS_DATA_BUF, 8'h5A);
        rdc(OFS_STAT_ONE, 8'h00, "buffer held");
        wr(OFS_CTRL_ONE, 8'h00);
        rdc(OFS_STAT_ONE, 8'hC0, "module off");
        $display("test_sleep done");
    endtask : test_sleep

    task automatic print_verdict();
        $display("counts: %0d compared, %0d wrong", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (8) @(posedge sysClk);
        rst <= 1'b0;
        @(posedge sysClk);
        test_regs();
        test_tx();
        test_rx();
        test_sleep();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge sysClk);
        errCount++;
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
